// file: verilog/cexc_pkg.sv
// Package of constants for the exception, interrupt and trap entry unit
package cexc_pkg;

  localparam int unsigned ADDR_W = 32;

  // Vector entry addresses
  localparam logic [31:0] VEC_RESET      = 32'h0000_0000;
  localparam logic [31:0] VEC_SYS_BREAK  = 32'h0000_0010;
  localparam logic [31:0] VEC_UNDEF_OP   = 32'h0000_0020;
  localparam logic [31:0] VEC_MISALIGN   = 32'h0000_0030;
  localparam logic [31:0] VEC_TRAP_BASE  = 32'h0000_0040;
  localparam logic [31:0] VEC_EXT_IRQ    = 32'h0000_0080;

  localparam logic [31:0] TRAP_PC_STEP   = 32'h0000_0004;
  localparam int unsigned TRAP_SHIFT     = 2;

  // Status flag values after reset
  localparam logic        RST_STACK_MODE = 1'h0;
  localparam logic        RST_INT_ENABLE = 1'h0;
  localparam logic        RST_CARRY      = 1'h0;

  // Load/store access sizes
  localparam logic [1:0]  SIZE_BYTE      = 2'h0;
  localparam logic [1:0]  SIZE_HALF      = 2'h1;
  localparam logic [1:0]  SIZE_WORD      = 2'h2;

  // Event codes, one-hot
  typedef enum logic [5:0] {
    CEXC_EV_NONE    = 6'h00,
    CEXC_EV_UNDEF   = 6'h01,
    CEXC_EV_MISAL   = 6'h02,
    CEXC_EV_TRAP    = 6'h04,
    CEXC_EV_SBREAK  = 6'h08,
    CEXC_EV_EXTIRQ  = 6'h10,
    CEXC_EV_RETURN  = 6'h20
  } cexc_event_type;

endpackage

// file: verilog/cexc_align_chk.sv
// Misaligned load/store detector
`timescale 1ns/1ps
module cexc_align_chk
  import cexc_pkg::*;
(
  input  wire logic [1:0] addr_low,      // Low address bits
  input  wire logic [1:0] access_size,   // Access size code
  input  wire logic       mem_access,    // Load or store active
  output logic            misaligned     // Address not size-aligned
);

  always_comb
  begin
    case (access_size)
      SIZE_HALF: misaligned = mem_access & addr_low[0];
      SIZE_WORD: misaligned = mem_access & (addr_low != 2'h0);
      default:   misaligned = 1'b0;
    endcase
  end

endmodule // cexc_align_chk

// file: verilog/cexc_entry.sv
// Exception, interrupt and trap entry and return unit of the CPU core
// Functional notes
// - Reserved opcode raises undefined-opcode fault
// - Misaligned load or store raises fault
// - Reset always accepted, never masked
// - Reset has highest priority
// - Trap n selects one of sixteen vectors
// - Non-reset entry saves PC, flags, then branches
// - Each event has its own vector address
// - Only PC and flags saved by hardware
// - Return restores PC and status flags
// - Undefined opcode: cancel, save own address
// - Misaligned access: cancel, save own address
// - Break and irq at word boundary, next PC
// - Trap saves trap address plus four
// - Fixed vector addresses per event kind
// - Entry backs up flags, clears enable, carry
// - Return restores flags and PC from backups
// - Undefined opcode beats coincident external irq
`timescale 1ns/1ps
module cexc_entry
  import cexc_pkg::*;
(
  input  wire logic        sys_clk,          // Core clock, 20 MHz
  input  wire logic        rst_b,            // Synchronous reset, active low
  input  wire logic        instr_valid,      // Instruction in execute stage
  input  wire logic [31:0] instr_pc,         // Address of executing instruction
  input  wire logic [31:0] next_pc,          // Address of following instruction
  input  wire logic        opcode_reserved,  // Decoder found reserved encoding
  input  wire logic        is_trap,          // Trap instruction
  input  wire logic [3:0]  trap_num,         // Trap operand
  input  wire logic        is_return,        // Return-from-handler instruction
  input  wire logic        mem_access,       // Load or store instruction
  input  wire logic [31:0] mem_addr,         // Load/store address
  input  wire logic [1:0]  mem_size,         // Load/store size code
  input  wire logic        wr_back_req,      // Instruction wants register write
  input  wire logic        mem_wr_req,       // Instruction wants memory write
  input  wire logic        system_break_int, // System break request
  input  wire logic        external_irq,     // Request from interrupt controller
  input  wire logic        carry_in,         // Carry flag update from ALU
  input  wire logic        carry_we,         // Carry flag write strobe
  input  wire logic        status_we,        // Live flag write strobe
  input  wire logic        stack_mode_in,    // Stack-mode value to write
  input  wire logic        int_enable_in,    // Interrupt-enable value to write
  output logic             reg_wr_en,        // Gated register write-back
  output logic             mem_wr_en,        // Gated memory write
  output logic             redirect,         // Load pc_target into PC
  output logic [31:0]      pc_target,        // New PC value
  output logic [31:0]      saved_pc,         // Backup PC
  output logic             stack_mode,       // Live stack-mode flag
  output logic             int_enable,       // Live interrupt-enable flag
  output logic             carry,            // Live carry flag
  output logic             saved_stack_mode, // Backup stack-mode
  output logic             saved_int_enable, // Backup interrupt-enable
  output logic             saved_carry,      // Backup carry
  output logic             undefined_opcode_fault,  // Fault pulse
  output logic             misaligned_access_fault, // Fault pulse
  output logic             exception_event          // Any entry this cycle
);

  logic           misaligned;
  logic           word_bound;
  logic           irq_ok;
  cexc_event_type ev_next;
  logic [31:0]    vec_next;
  logic [31:0]    bpc_next;

  // ----------------------------------------
  // Event detection and priority
  // ----------------------------------------
  cexc_align_chk u_align (
    .addr_low    (mem_addr[1:0]),
    .access_size (mem_size),
    .mem_access  (mem_access & instr_valid),
    .misaligned  (misaligned)
  );

  assign word_bound = (next_pc[1:0] == 2'h0);
  assign irq_ok     = instr_valid & word_bound;

  // Faults outrank requests sampled at the same boundary
  always_comb
  begin
    if (instr_valid & opcode_reserved)
      ev_next = CEXC_EV_UNDEF;
    else if (misaligned)
      ev_next = CEXC_EV_MISAL;
    else if (instr_valid & is_trap)
      ev_next = CEXC_EV_TRAP;
    else if (instr_valid & is_return)
      ev_next = CEXC_EV_RETURN;
    else if (irq_ok & system_break_int)
      ev_next = CEXC_EV_SBREAK;
    else if (irq_ok & int_enable & external_irq)
      ev_next = CEXC_EV_EXTIRQ;
    else
      ev_next = CEXC_EV_NONE;
  end

  always_comb
  begin
    vec_next = VEC_RESET;
    bpc_next = saved_pc;
    case (ev_next)
      CEXC_EV_UNDEF:  begin vec_next = VEC_UNDEF_OP;  bpc_next = instr_pc; end
      CEXC_EV_MISAL:  begin vec_next = VEC_MISALIGN;  bpc_next = instr_pc; end
      CEXC_EV_TRAP:
      begin
        vec_next = VEC_TRAP_BASE + {26'h0, trap_num, 2'h0};
        bpc_next = instr_pc + TRAP_PC_STEP;
      end
      CEXC_EV_SBREAK: begin vec_next = VEC_SYS_BREAK; bpc_next = next_pc;  end
      CEXC_EV_EXTIRQ: begin vec_next = VEC_EXT_IRQ;   bpc_next = next_pc;  end
      CEXC_EV_RETURN: begin vec_next = {saved_pc[31:2], 2'h0}; end
      CEXC_EV_NONE:   begin vec_next = VEC_RESET; end
      default:        begin vec_next = VEC_RESET; end
    endcase
  end

  // ----------------------------------------
  // Side-effect gating
  // ----------------------------------------
  // Cancelled instructions must not commit
  assign reg_wr_en = wr_back_req & instr_valid & rst_b
                     & (ev_next != CEXC_EV_UNDEF) & (ev_next != CEXC_EV_MISAL);
  assign mem_wr_en = mem_wr_req & instr_valid & rst_b
                     & (ev_next != CEXC_EV_UNDEF) & (ev_next != CEXC_EV_MISAL);

  // ----------------------------------------
  // Redirect and backup PC
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      redirect  <= 1'b1;
      pc_target <= VEC_RESET;
      exception_event <= 1'b1;
      undefined_opcode_fault  <= 1'b0;
      misaligned_access_fault <= 1'b0;
    end
    else
    begin
      redirect  <= (ev_next != CEXC_EV_NONE);
      pc_target <= vec_next;
      exception_event <= (ev_next != CEXC_EV_NONE) & (ev_next != CEXC_EV_RETURN);
      undefined_opcode_fault  <= (ev_next == CEXC_EV_UNDEF);
      misaligned_access_fault <= (ev_next == CEXC_EV_MISAL);
    end
  end

  // Cleared by reset although software must treat it as undefined
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      saved_pc <= 32'h0000_0000;
    else if ((ev_next != CEXC_EV_NONE) & (ev_next != CEXC_EV_RETURN))
      saved_pc <= bpc_next;
  end

  // ----------------------------------------
  // Status flags and backups
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      stack_mode <= RST_STACK_MODE;
      int_enable <= RST_INT_ENABLE;
      carry      <= RST_CARRY;
      saved_stack_mode <= RST_STACK_MODE;
      saved_int_enable <= RST_INT_ENABLE;
      saved_carry      <= RST_CARRY;
    end
    else if (ev_next == CEXC_EV_RETURN)
    begin
      stack_mode <= saved_stack_mode;
      int_enable <= saved_int_enable;
      carry      <= saved_carry;
    end
    else if (ev_next != CEXC_EV_NONE)
    begin
      saved_stack_mode <= stack_mode;
      saved_int_enable <= int_enable;
      saved_carry      <= carry;
      int_enable <= 1'b0;
      carry      <= 1'b0;
      if ((ev_next == CEXC_EV_SBREAK) | (ev_next == CEXC_EV_EXTIRQ))
        stack_mode <= 1'b0;
    end
    else
    begin
      // Software sets the flags; without this no interrupt could ever be enabled
      if (status_we & instr_valid)
      begin
        stack_mode <= stack_mode_in;
        int_enable <= int_enable_in;
      end
      if (carry_we & instr_valid)
        carry <= carry_in;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_undef_seen;
    instr_valid && opcode_reserved;
  endsequence

  sequence s_entry(logic [31:0] v);
    redirect && (pc_target == v);
  endsequence

  a_undef_vector: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_undef_seen |=> s_entry(VEC_UNDEF_OP) and (saved_pc == $past(instr_pc)))
    else $error("undefined opcode entry wrong");

  a_undef_beats_irq: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_undef_seen and (external_irq && int_enable)) |=> undefined_opcode_fault)
    else $error("irq taken over undefined opcode");

  a_misal_vector: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (misaligned && !opcode_reserved) |=> s_entry(VEC_MISALIGN) and (saved_pc == $past(instr_pc)))
    else $error("misaligned entry wrong");

  a_trap_vector: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ev_next == CEXC_EV_TRAP) |=> s_entry(VEC_TRAP_BASE + {26'h0, $past(trap_num), 2'h0})
      and (saved_pc == $past(instr_pc) + TRAP_PC_STEP))
    else $error("trap entry wrong");

  a_irq_boundary: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ev_next == CEXC_EV_EXTIRQ) |-> word_bound ##1 (s_entry(VEC_EXT_IRQ) and !stack_mode))
    else $error("external irq entry wrong");

  a_entry_flags: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ((ev_next != CEXC_EV_NONE) && (ev_next != CEXC_EV_RETURN)) |=>
      !int_enable && !carry && (saved_int_enable == $past(int_enable)) && (saved_carry == $past(carry)))
    else $error("entry flag update wrong");

  a_return_restore: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ev_next == CEXC_EV_RETURN) |=> (int_enable == $past(saved_int_enable))
      && (pc_target == {$past(saved_pc[31:2]), 2'h0}))
    else $error("return restore wrong");

  a_no_commit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_undef_seen |-> !reg_wr_en && !mem_wr_en)
    else $error("cancelled instruction committed");

  a_reset_first: assert property (@(posedge sys_clk)
    !rst_b |=> redirect && (pc_target == VEC_RESET) && !int_enable)
    else $error("reset entry wrong");

endmodule // cexc_entry

// file: bench/cexc_irq_src.sv
// Model of the interrupt controller and the system break source
`timescale 1ns/1ps
module cexc_irq_src
(
  input  wire logic       brk_cmd,          // Bench asks for a break
  input  wire logic       irq_cmd,          // Bench asks for a request
  input  wire logic [2:0] irq_level,        // Source level, 0 disabled
  output logic            system_break_int, // Break level to core
  output logic            external_irq      // Request to core
);
  // Level 0 of eight means disabled, so it never reaches the core
  assign external_irq = irq_cmd && (irq_level != 3'h0);
  // Bench never returns after a break
  assign system_break_int = brk_cmd;
endmodule // cexc_irq_src

// file: bench/tb.sv
// Self-checking bench for the exception entry unit
`timescale 1ns/1ps
module tb import cexc_pkg::*;
;
  // --------------------
  // Signals
  // --------------------
  localparam logic [12:0] K_V = 13'h0001, K_RES = 13'h0002, K_TRAP = 13'h0004, K_RET = 13'h0008, K_MEM = 13'h0010;
  localparam logic [12:0] K_WB = 13'h0020, K_MW = 13'h0040, K_CW = 13'h0080, K_BRK = 13'h0100, K_IRQ = 13'h0200;
  localparam logic [12:0] K_SW = 13'h0400, K_SMI = 13'h0800, K_IEI = 13'h1000;
  logic        sys_clk = 1'h0, rst_b = 1'h0, instr_valid = 1'h0, opcode_reserved = 1'h0, is_trap = 1'h0;
  logic        is_return = 1'h0, mem_access = 1'h0, wr_back_req = 1'h0, mem_wr_req = 1'h0, carry_we = 1'h0;
  logic        brk_cmd = 1'h0, irq_cmd = 1'h0, carry_in = 1'h1, wb_seen, mw_seen;
  logic        status_we = 1'h0, stack_mode_in = 1'h0, int_enable_in = 1'h0;
  logic [2:0]  irq_level = 3'h5;
  logic [31:0] instr_pc = 32'h0, next_pc = 32'h0, mem_addr = 32'h0, pc_target, saved_pc;
  logic [3:0]  trap_num = 4'h0;
  logic [1:0]  mem_size = 2'h0;
  logic        system_break_int, external_irq, reg_wr_en, mem_wr_en, redirect, stack_mode, int_enable, carry;
  logic        saved_stack_mode, saved_int_enable, saved_carry, undefined_opcode_fault, misaligned_access_fault;
  logic        exception_event;
  int          num_errors = 0, compares = 0;

  always #25 sys_clk = ~sys_clk;

  cexc_irq_src i_src (.brk_cmd(brk_cmd), .irq_cmd(irq_cmd), .irq_level(irq_level),
    .system_break_int(system_break_int), .external_irq(external_irq));
  cexc_entry i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_pc(instr_pc),
    .next_pc(next_pc), .opcode_reserved(opcode_reserved), .is_trap(is_trap), .trap_num(trap_num),
    .is_return(is_return), .mem_access(mem_access), .mem_addr(mem_addr), .mem_size(mem_size),
    .wr_back_req(wr_back_req), .mem_wr_req(mem_wr_req), .system_break_int(system_break_int),
    .external_irq(external_irq), .carry_in(carry_in), .carry_we(carry_we), .status_we(status_we),
    .stack_mode_in(stack_mode_in), .int_enable_in(int_enable_in), .reg_wr_en(reg_wr_en),
    .mem_wr_en(mem_wr_en), .redirect(redirect), .pc_target(pc_target), .saved_pc(saved_pc),
    .stack_mode(stack_mode), .int_enable(int_enable), .carry(carry), .saved_stack_mode(saved_stack_mode),
    .saved_int_enable(saved_int_enable), .saved_carry(saved_carry),
    .undefined_opcode_fault(undefined_opcode_fault), .misaligned_access_fault(misaligned_access_fault),
    .exception_event(exception_event));

  // --------------------
  // Shared tasks
  // --------------------
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    begin
      compares++;
      if (seen !== exp)
      begin
        num_errors++;
        $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  task conclude;
    begin
      if (num_errors == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  task drive(input logic [31:0] pc, input logic [31:0] npc, input logic [12:0] k, input logic [31:0] addr,
             input logic [1:0] size, input logic [3:0] tn);
    begin
      instr_pc <= pc;
      next_pc <= npc;
      instr_valid <= k[0];
      opcode_reserved <= k[1];
      is_trap <= k[2];
      is_return <= k[3];
      mem_access <= k[4];
      wr_back_req <= k[5];
      mem_wr_req <= k[6];
      carry_we <= k[7];
      brk_cmd <= k[8];
      irq_cmd <= k[9];
      status_we <= k[10];
      stack_mode_in <= k[11];
      int_enable_in <= k[12];
      mem_addr <= addr;
      mem_size <= size;
      trap_num <= tn;
    end
  endtask

  // One instruction cycle, then an idle cycle; answer lands one edge later
  task step(input logic [31:0] pc, input logic [31:0] npc, input logic [12:0] k, input logic [31:0] addr,
            input logic [1:0] size, input logic [3:0] tn);
    begin
      @(posedge sys_clk);
      drive(pc, npc, k, addr, size, tn);
      #1;
      wb_seen = reg_wr_en;
      mw_seen = mem_wr_en;
      @(posedge sys_clk);
      drive(32'h0, 32'h0, 13'h0, 32'h0, 2'h0, 4'h0);
      #1;
    end
  endtask

  // --------------------
  // Scenarios
  // --------------------
  // Interrupts enabled first, so the coincident request really competes
  task s_undef;
    begin
      step(32'h100, 32'h104, K_V | K_SW | K_IEI, 32'h0, 2'h0, 4'h0);
      step(32'h106, 32'h108, K_V | K_RES | K_WB | K_MW | K_IRQ, 32'h0, 2'h0, 4'h0);
      chk("reg_wr_en", wb_seen, 1'h0);
      chk("mem_wr_en", mw_seen, 1'h0);
      chk("undefined_opcode_fault", undefined_opcode_fault, 1'h1);
      chk("pc_target", pc_target, VEC_UNDEF_OP);
      chk("saved_pc", saved_pc, 32'h106);
      chk("exception_event", exception_event, 1'h1);
      chk("int_enable", int_enable, 1'h0);
      chk("saved_int_enable", saved_int_enable, 1'h1);
    end
  endtask

  task s_misal;
    logic [1:0] sz;
    logic       bad;
    begin
      for (int i = 0; i < 3; i++)
      begin
        sz = (i == 0) ? SIZE_HALF : (i == 1) ? SIZE_WORD : SIZE_BYTE;
        bad = (i != 2);
        step(32'h200 + 32'(i * 4), 32'h204 + 32'(i * 4), K_V | K_MEM | K_MW, 32'h8000_0001 + 32'(i), sz, 4'h0);
        chk("misaligned_access_fault", misaligned_access_fault, bad);
        chk("mem_wr_en", mw_seen, !bad);
        chk("redirect", redirect, bad);
        if (bad)
        begin
          chk("saved_pc", saved_pc, 32'h200 + 32'(i * 4));
          chk("pc_target", pc_target, VEC_MISALIGN);
        end
      end
    end
  endtask

  // Requests masked by level, by word boundary and by the enable flag
  task s_irq;
    begin
      step(32'h500, 32'h504, K_V | K_SW | K_SMI | K_IEI, 32'h0, 2'h0, 4'h0);
      irq_level <= 3'h0;
      step(32'h504, 32'h508, K_V | K_IRQ, 32'h0, 2'h0, 4'h0);
      chk("redirect", redirect, 1'h0);
      irq_level <= 3'h5;
      step(32'h508, 32'h50a, K_V | K_IRQ, 32'h0, 2'h0, 4'h0);
      chk("redirect", redirect, 1'h0);
      step(32'h50a, 32'h50c, K_V | K_IRQ, 32'h0, 2'h0, 4'h0);
      chk("pc_target", pc_target, VEC_EXT_IRQ);
      chk("saved_pc", saved_pc, 32'h50c);
      chk("stack_mode", stack_mode, 1'h0);
      chk("saved_stack_mode", saved_stack_mode, 1'h1);
      chk("int_enable", int_enable, 1'h0);
      step(32'h80, 32'h84, K_V | K_IRQ, 32'h0, 2'h0, 4'h0);
      chk("redirect", redirect, 1'h0);
      step(32'h84, 32'h88, K_V | K_RET, 32'h0, 2'h0, 4'h0);
      chk("pc_target", pc_target, 32'h50c);
      chk("stack_mode", stack_mode, 1'h1);
      chk("int_enable", int_enable, 1'h1);
    end
  endtask

  // Half-word trap addresses make the return clear the low bits
  task s_trap;
    logic [31:0] pc;
    begin
      for (int n = 0; n < 16; n++)
      begin
        pc = 32'h1002 + 32'(n * 8);
        step(pc, pc + 32'h2, K_V | K_CW, 32'h0, 2'h0, 4'h0);
        step(pc, pc + 32'h4, K_V | K_TRAP, 32'h0, 2'h0, 4'(n));
        chk("pc_target", pc_target, VEC_TRAP_BASE + 32'(n * 4));
        chk("saved_pc", saved_pc, pc + 32'h4);
        chk("saved_carry", saved_carry, 1'h1);
        chk("carry", carry, 1'h0);
        chk("stack_mode", stack_mode, 1'h1);
      end
      step(32'h3000, 32'h3004, K_V | K_RET, 32'h0, 2'h0, 4'h0);
      chk("redirect", redirect, 1'h1);
      chk("pc_target", pc_target, 32'h107c);
      chk("carry", carry, 1'h1);
    end
  endtask

  task s_break;
    begin
      step(32'h400, 32'h402, K_V | K_BRK, 32'h0, 2'h0, 4'h0);
      chk("redirect", redirect, 1'h0);
      step(32'h404, 32'h408, K_V | K_BRK, 32'h0, 2'h0, 4'h0);
      chk("pc_target", pc_target, VEC_SYS_BREAK);
      chk("saved_pc", saved_pc, 32'h408);
      chk("saved_carry", saved_carry, 1'h1);
      chk("stack_mode", stack_mode, 1'h0);
      chk("saved_stack_mode", saved_stack_mode, 1'h1);
    end
  endtask

  // Reset lands on the same edge as a trap that wants to write back
  task s_reset;
    begin
      step(32'h600, 32'h604, K_V | K_CW, 32'h0, 2'h0, 4'h0);
      @(posedge sys_clk);
      drive(32'h604, 32'h608, K_V | K_TRAP | K_WB | K_MW, 32'h0, 2'h0, 4'h3);
      rst_b <= 1'h0;
      @(posedge sys_clk);
      #1;
      chk("redirect", redirect, 1'h1);
      chk("pc_target", pc_target, VEC_RESET);
      chk("exception_event", exception_event, 1'h1);
      chk("reg_wr_en", reg_wr_en, 1'h0);
      chk("carry", carry, 1'h0);
      @(posedge sys_clk);
      rst_b <= 1'h1;
      drive(32'h0, 32'h0, 13'h0, 32'h0, 2'h0, 4'h0);
      @(posedge sys_clk);
    end
  endtask

  initial
  begin
    #2_000_000;
    num_errors++;
    conclude;
  end

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'h1;
    s_undef;
    s_misal;
    s_irq;
    s_trap;
    s_break;
    s_reset;
    conclude;
  end
endmodule // tb
